// *** hdl/hps_regs.sv ***
module hps_regs
    import hps_pkg::*;
(
    input  wire logic       clk,        // 100 MHz clock
    input  wire logic       rst_n,      // Asynchronous reset, active low
    input  wire logic [7:0] addr,       // Register address
    input  wire logic [7:0] wdata,      // Write data
    input  wire logic       wr,         // Write strobe
    input  wire logic       rd,         // Read strobe
    output logic      [7:0] rdata,      // Read data, one cycle after rd
    output hps_startup_t    startup,    // Decoded start-up settings
    output logic      [6:0] left_vol,   // Left input-to-headphone volume
    output logic      [9:0] left_atten  // Attenuation, tenths of dB
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------

    // Ramp length in 1/40 time constants; 32 constants need 11 bits
    function automatic logic [10:0] ramp_x40(input logic [3:0] code);
        case (code)
            4'h0:    ramp_x40 = 11'h000;
            4'h1:    ramp_x40 = 11'h014;
            4'h2:    ramp_x40 = 11'h019;
            4'h3:    ramp_x40 = 11'h01D;
            4'h4:    ramp_x40 = 11'h023;
            4'h5:    ramp_x40 = 11'h028;
            4'h6:    ramp_x40 = 11'h050;
            4'h7:    ramp_x40 = 11'h078;
            4'h8:    ramp_x40 = 11'h0C8;
            4'h9:    ramp_x40 = 11'h0F0;
            4'hA:    ramp_x40 = 11'h118;
            4'hB:    ramp_x40 = 11'h118; // Same 7 constants as 1010
            4'hC:    ramp_x40 = 11'h140;
            4'hD:    ramp_x40 = 11'h280;
            4'hE:    ramp_x40 = 11'h3C0;
            default: ramp_x40 = 11'h500;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] startup_reg;
    logic [6:0] vol_reg;

    // Address decode
    wire hit_startup = addr == HPS_ADDR_STARTUP;
    wire hit_lvol    = addr == HPS_ADDR_LVOLUME;
    wire hit_rsv     = addr == HPS_ADDR_RESERVED;

    // Field views of the start-up register
    wire [1:0] step_f = startup_reg[HPS_STEP_LSB +: 2];
    wire [3:0] ramp_f = startup_reg[HPS_RAMP_LSB +: 4];
    wire [1:0] rchg_f = startup_reg[HPS_RCHG_LSB +: 2];

    // Read mux; reserved register and volume top bit read zero
    wire [7:0] next_rdata = !rd          ? 8'h00 :
                            hit_startup  ? startup_reg :
                            hit_rsv      ? HPS_RESERVED_VAL :
                            hit_lvol     ? {1'b0, vol_reg} :
                                           8'h00;

    // Decoded settings
    hps_startup_t next_startup;
    always_comb begin
        next_startup = '0;
        case (step_f)
            2'h1:    next_startup.step_ms = HPS_STEP_MS1;
            2'h2:    next_startup.step_ms = HPS_STEP_MS2;
            2'h3:    next_startup.step_ms = HPS_STEP_MS3;
            default: next_startup.step_ms = 8'h00;
        endcase
        next_startup.ramp_slow   = ramp_f != 4'h0;
        next_startup.ramp_tc_x40 = ramp_x40(ramp_f);
        case (rchg_f)
            HPS_RCHG_6K: next_startup.rchg_kohm = HPS_KOHM_6;
            HPS_RCHG_2K: next_startup.rchg_kohm = HPS_KOHM_2;
            default:     next_startup.rchg_kohm = HPS_KOHM_25;
        endcase
        next_startup.cfg_error = (rchg_f == HPS_RCHG_RSV) ||
            (rchg_f == HPS_RCHG_25K && ramp_f >= HPS_RAMP_LIM25);
    end

    // Attenuation for the documented volume codes
    wire [9:0] next_atten = (vol_reg == HPS_VOL_A) ? HPS_VOL_A_DB :
                            (vol_reg == HPS_VOL_B) ? HPS_VOL_B_DB :
                                                     10'h000;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startup_reg <= HPS_STARTUP_RST;
            vol_reg     <= HPS_VOLUME_RST;
        end else if (wr && hit_startup) begin
            startup_reg <= wdata;
        end else if (wr && hit_lvol) begin
            vol_reg     <= wdata[6:0];
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata      <= 8'h00;
            startup    <= '0;
            left_vol   <= 7'h00;
            left_atten <= 10'h000;
        end else begin
            rdata      <= next_rdata;
            startup    <= next_startup;
            left_vol   <= vol_reg;
            left_atten <= next_atten;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    // Write strobes and field views of the bus data
    wire       wr_startup = wr && hit_startup;
    wire       wr_lvol    = wr && hit_lvol;
    wire [1:0] wr_step    = wdata[HPS_STEP_LSB +: 2];
    wire [3:0] wr_ramp    = wdata[HPS_RAMP_LSB +: 4];
    wire [1:0] wr_rchg    = wdata[HPS_RCHG_LSB +: 2];

    // ----------------------------------------------------------------
    // Bus and storage checks
    // ----------------------------------------------------------------

    // Reserved register reads back as zero
    rsv_reads_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd && hit_rsv |=> rdata == HPS_RESERVED_VAL)
        else $error("reserved register not zero");

    // Volume top bit always reads zero
    vol_top_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd && hit_lvol |=> rdata[7] == 1'b0)
        else $error("volume bit 7 set");

    // A start-up read right behind a start-up write returns the written byte
    startup_readback_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup ##1 rd && hit_startup |=> rdata == $past(wdata, 2))
        else $error("start-up readback wrong");

    // Volume readback drops the top bit of the written byte
    vol_readback_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_lvol ##1 rd && hit_lvol |=> rdata == ($past(wdata, 2) & 8'h7F))
        else $error("volume readback wrong");

    // Read data stand only in the cycle after a read
    rdata_idle_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !rd |=> rdata == 8'h00)
        else $error("read data without read");

    // A start-up write lands in one edge
    startup_capture_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup |=> startup_reg == $past(wdata))
        else $error("start-up write lost");

    // Without a write the start-up register holds
    startup_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !wr_startup |=> $stable(startup_reg))
        else $error("start-up register changed");

    // A volume write lands without its top bit
    vol_capture_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_lvol |=> {1'b0, vol_reg} == ($past(wdata) & 8'h7F))
        else $error("volume write lost");

    // Without a write the volume register holds
    vol_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !wr_lvol |=> $stable(vol_reg))
        else $error("volume register changed");

    // Writes to the reserved slot touch no storage
    rsv_write_ignored_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr && hit_rsv |=> $stable(startup_reg) && $stable(vol_reg))
        else $error("reserved write stored");

    // ----------------------------------------------------------------
    // Start-up decode checks
    // ----------------------------------------------------------------

    // Step code 00 gives no routing delay
    step_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_step == 2'h0 |=> ##1 startup.step_ms == 8'h00)
        else $error("step time not zero");

    // Step code 01 gives the short delay
    step_fifty_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_step == 2'h1 |=> ##1 startup.step_ms == HPS_STEP_MS1)
        else $error("step time not short");

    // Step code 10 gives the middle delay
    step_decode_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_step == 2'h2 |=> ##1 startup.step_ms == HPS_STEP_MS2)
        else $error("step time wrong");

    // Step code 11 gives the long delay
    step_long_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_step == 2'h3 |=> ##1 startup.step_ms == HPS_STEP_MS3)
        else $error("step time not long");

    // Ramp code zero powers up at once
    ramp_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_ramp == 4'h0 |=> ##1 !startup.ramp_slow)
        else $error("ramp not off");

    // Any other ramp code selects the slow power-up
    ramp_slow_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_ramp != 4'h0 |=> ##1 startup.ramp_slow)
        else $error("slow ramp not selected");

    // Shortest slow ramp is half a time constant
    ramp_half_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_ramp == 4'h1 |=> ##1
        startup.ramp_slow && startup.ramp_tc_x40 == 11'h014)
        else $error("ramp length wrong");

    // Code 0101 ramps over one time constant
    ramp_unit_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_ramp == 4'h5 |=> ##1 startup.ramp_tc_x40 == 11'h028)
        else $error("one constant ramp wrong");

    // Code 1100 ramps over eight time constants
    ramp_eight_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_ramp == 4'hC |=> ##1 startup.ramp_tc_x40 == 11'h140)
        else $error("eight constant ramp wrong");

    // Longest ramp is 32 time constants, not clipped
    ramp_full_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_ramp == 4'hF |=> ##1 startup.ramp_tc_x40 == 11'h500)
        else $error("longest ramp wrong");

    // Charging code 00 selects the high resistance
    rchg_25k_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_rchg == HPS_RCHG_25K |=> ##1
        startup.rchg_kohm == HPS_KOHM_25)
        else $error("charging 25k wrong");

    // Charging code 01 selects the middle resistance
    rchg_decode_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_rchg == HPS_RCHG_6K |=> ##1
        startup.rchg_kohm == HPS_KOHM_6)
        else $error("charging 6k wrong");

    // Charging code 10 selects the low resistance
    rchg_2k_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_rchg == HPS_RCHG_2K |=> ##1
        startup.rchg_kohm == HPS_KOHM_2)
        else $error("charging 2k wrong");

    // ----------------------------------------------------------------
    // Illegal setting checks
    // ----------------------------------------------------------------

    // Reserved charging code is flagged
    rsv_code_err_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_rchg == HPS_RCHG_RSV |=> ##1 startup.cfg_error)
        else $error("reserved charging code not flagged");

    // Long ramps with the high resistance are flagged
    ramp_limit_err_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && wr_rchg == HPS_RCHG_25K && wr_ramp >= HPS_RAMP_LIM25
        |=> ##1 startup.cfg_error)
        else $error("long ramp at 25k not flagged");

    // Low and middle resistance never raise the flag
    legal_no_err_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_startup && (wr_rchg == HPS_RCHG_6K || wr_rchg == HPS_RCHG_2K)
        |=> ##1 !startup.cfg_error)
        else $error("legal setting flagged");

    // ----------------------------------------------------------------
    // Volume checks
    // ----------------------------------------------------------------

    // Code 100 0010 reports its attenuation
    vol_atten_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_lvol && wdata[6:0] == HPS_VOL_B |=> ##1 left_atten == HPS_VOL_B_DB)
        else $error("attenuation wrong");

    // Code 100 0001 reports its attenuation
    vol_atten_low_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_lvol && wdata[6:0] == HPS_VOL_A |=> ##1 left_atten == HPS_VOL_A_DB)
        else $error("low attenuation wrong");

    // Volume output follows the written field two edges on
    left_vol_follow_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_lvol |=> ##1 {1'b0, left_vol} == ($past(wdata, 2) & 8'h7F))
        else $error("volume output wrong");

endmodule

// *** common/hps_pkg.sv ***
// Operation
// - Step field 00/01/10/11 gives 0, 50, 100 or 200 ms per routing step.
// - Ramp code 0000 powers the headphone amplifiers up at once, no ramp.
// - Nonzero ramp codes ramp slowly, 0.5 time constants up to 32 at 1111.
// - Charging field 00, 01, 10 selects 25, 6 or 2 kilohm to time the ramp.
// - The reserved register after it reads zero and takes only zero writes.
// - Volume register bit 7 reads zero and software writes it only as zero.
// - Volume code 100 0001 is -32.6 dB and 100 0010 is -33.1 dB attenuation.
package hps_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] HPS_ADDR_STARTUP  = 8'h14;
    localparam logic [7:0] HPS_ADDR_RESERVED = 8'h15;
    localparam logic [7:0] HPS_ADDR_LVOLUME  = 8'h16;

    // Field positions
    localparam int HPS_STEP_LSB = 6;
    localparam int HPS_RAMP_LSB = 2;
    localparam int HPS_RCHG_LSB = 0;

    // Reset values
    localparam logic [7:0] HPS_STARTUP_RST  = 8'h00;
    localparam logic [7:0] HPS_RESERVED_VAL = 8'h00;
    localparam logic [6:0] HPS_VOLUME_RST   = 7'h00;

    // Routing step times in ms
    localparam logic [7:0] HPS_STEP_MS1 = 8'h32;
    localparam logic [7:0] HPS_STEP_MS2 = 8'h64;
    localparam logic [7:0] HPS_STEP_MS3 = 8'hC8;

    // Charging resistance codes
    localparam logic [1:0] HPS_RCHG_25K = 2'h0;
    localparam logic [1:0] HPS_RCHG_6K  = 2'h1;
    localparam logic [1:0] HPS_RCHG_2K  = 2'h2;
    localparam logic [1:0] HPS_RCHG_RSV = 2'h3;

    // Charging resistance in kilohm
    localparam logic [4:0] HPS_KOHM_25 = 5'h19;
    localparam logic [4:0] HPS_KOHM_6  = 5'h06;
    localparam logic [4:0] HPS_KOHM_2  = 5'h02;

    // First ramp code illegal with 25 kilohm
    localparam logic [3:0] HPS_RAMP_LIM25 = 4'hD;

    // Volume codes with known attenuation, in tenths of dB
    localparam logic [6:0]  HPS_VOL_A     = 7'h41;
    localparam logic [6:0]  HPS_VOL_B     = 7'h42;
    localparam logic [9:0]  HPS_VOL_A_DB  = 10'h146;
    localparam logic [9:0]  HPS_VOL_B_DB  = 10'h14B;

    // Decoded start-up settings
    typedef struct packed {
        logic [7:0]  step_ms;     // routing step time in ms
        logic        ramp_slow;   // slow ramp enabled
        logic [10:0] ramp_tc_x40; // ramp length in 1/40 time constants
        logic [4:0]  rchg_kohm;   // charging resistance in kilohm
        logic        cfg_error;   // illegal setting programmed
    } hps_startup_t;

endpackage

// *** bench/test_hps_regs.sv ***
module test_hps_regs import hps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals and device
    // ------------------------------------------------------------
    logic         clk, rst_n, wr, rd;
    logic [7:0]   addr, wdata, rdata;
    hps_startup_t startup;
    logic [6:0]   left_vol;
    logic [9:0]   left_atten;
    int           errors, cmp_count;
    // Ramp lengths in 1/40 time constants, up to 32 constants
    localparam logic [10:0] RAMP [16] = '{11'h000, 11'h014, 11'h019,
        11'h01D, 11'h023, 11'h028, 11'h050, 11'h078, 11'h0C8, 11'h0F0,
        11'h118, 11'h118, 11'h140, 11'h280, 11'h3C0, 11'h500};
    localparam logic [7:0] STEP [4] = '{8'h00, 8'h32, 8'h64, 8'hC8};
    localparam logic [4:0] KOHM [3] = '{5'h19, 5'h06, 5'h02};
    hps_regs i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .startup(startup),
        .left_vol(left_vol), .left_atten(left_atten));
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write, then wait until the decoded outputs have settled
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(startup, 26'h0000000);
        rd_chk(HPS_ADDR_STARTUP, 8'h00);
        rd_chk(HPS_ADDR_RESERVED, 8'h00);
        rd_chk(HPS_ADDR_LVOLUME, 8'h00);
    endtask
    task automatic t_step();
        for (int i = 0; i < 4; i++) begin
            wr_reg(HPS_ADDR_STARTUP, {i[1:0], 6'h05});
            chk(startup.step_ms, STEP[i]);
            rd_chk(HPS_ADDR_STARTUP, {i[1:0], 6'h05});
        end
    endtask
    task automatic t_ramp();
        for (int i = 0; i < 16; i++) begin
            wr_reg(HPS_ADDR_STARTUP, {2'h2, i[3:0], 2'h1});
            chk(startup.ramp_tc_x40, RAMP[i]);
            chk(startup.ramp_slow, i != 0);
            chk(startup.cfg_error, 1'b0);
        end
    endtask
    task automatic t_rchg();
        for (int i = 0; i < 3; i++) begin
            wr_reg(HPS_ADDR_STARTUP, {6'h04, i[1:0]});
            chk(startup.rchg_kohm, KOHM[i]);
            chk(startup.cfg_error, 1'b0);
        end
        wr_reg(HPS_ADDR_STARTUP, 8'h34);
        chk(startup.cfg_error, 1'b1);
        wr_reg(HPS_ADDR_STARTUP, 8'h07);
        chk(startup.cfg_error, 1'b1);
    endtask
    task automatic t_rsvd();
        wr_reg(HPS_ADDR_RESERVED, 8'hFF);
        rd_chk(HPS_ADDR_RESERVED, 8'h00);
        wr_reg(8'h30, 8'hA5);
        rd_chk(8'h30, 8'h00);
        rd_chk(HPS_ADDR_STARTUP, 8'h07);
    endtask
    task automatic t_vol();
        wr_reg(HPS_ADDR_LVOLUME, 8'hC1);
        rd_chk(HPS_ADDR_LVOLUME, 8'h41);
        chk(left_atten, 10'h146);
        wr_reg(HPS_ADDR_LVOLUME, 8'h42);
        chk(left_vol, 7'h42);
        chk(left_atten, 10'h14B);
    endtask
    // Write then read with no gap between the strobes
    task automatic t_b2b();
        @(posedge clk);
        wr <= 1'b1;
        addr <= HPS_ADDR_STARTUP;
        wdata <= 8'h99;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, 8'h99);
        chk(startup.step_ms, 8'h64);
        @(posedge clk);
        wr <= 1'b1;
        addr <= HPS_ADDR_LVOLUME;
        wdata <= 8'h41;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, 8'h41);
        chk(left_vol, 7'h41);
        chk(left_atten, 10'h146);
    endtask
    // ------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Reset for two cycles, then run every scenario
    initial begin
        errors = 0; cmp_count = 0;
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        t_reset(); t_step(); t_ramp(); t_rchg(); t_rsvd(); t_vol();
        t_b2b();
        summarize();
    end
    // Cut a hang short well past the expected run of about 120 cycles
    initial begin
        #20us;
        errors++;
        summarize();
    end
endmodule
